// *** design/tps_pkg.sv ***
// Package for the timing packet steering and statistics block.
// Assumes one system clock domain; packet-port clocks arrive as plain inputs.
package tps_pkg;

  // ----------------------------------------------------------------
  // Connection modes and routes
  // ----------------------------------------------------------------
  localparam logic [1:0] TPS_MODE_SNOOP = 2'h0;
  localparam logic [1:0] TPS_MODE_PASS = 2'h1;
  localparam logic [1:0] TPS_MODE_ALONE = 2'h2;

  typedef enum logic [3:0] {
    TPS_RT_DROP = 4'h1,
    TPS_RT_FWD = 4'h2,
    TPS_RT_HOST = 4'h4,
    TPS_RT_REC = 4'h8
  } tps_route_t;

  // ----------------------------------------------------------------
  // Widths, counts and reset values
  // ----------------------------------------------------------------
  localparam int TPS_STREAMS = 4;
  localparam int TPS_CNT_W = 32;
  localparam int TPS_SEQ_W = 16;
  localparam int TPS_DV_W = 16;
  localparam int TPS_DV_UNIT_US = 125;
  localparam logic [31:0] TPS_CNT_RST = 32'h0000_0000;
  localparam logic [15:0] TPS_SEQ_HALF = 16'h8000;
  localparam logic [15:0] TPS_DV_RST = 16'h0000;

endpackage

// *** design/tps_steer.sv ***
// Timing packet steering between two packet ports, the clock recovery
// path and the host, plus per-stream receive statistics.
// Assumes a classifier on MCLK gives each port a timing verdict by the
// frame's first byte, and one result pulse per accepted timing packet.
//
// Summary of operation
// - Listen-only mode drops non-timing, delivers timing packets.
// - Listen-only mode never transmits on any port.
// - Pass-through forwards non-timing packets to opposite port.
// - Pass-through diverts timing packets to timing processing.
// - Customer-side packets relay unchanged to provider side.
// - Own timing packets merge into provider-bound flow.
// - Standalone extracts timing, sends port 1 non-timing toward host.
// - Host path is DMA queue or second port.
// - Count accepted timing packets per stream, 32 bits.
// - Accumulate payload octets per stream, 32 bits.
// - Count lost packets from sequence gaps, 32 bits.
// - Report extended highest sequence, wraps in upper half.
// - Keep min and max delay variation per period.
// - All logic runs from the system clock.
`timescale 1ns/1ps
module tps_steer
  import tps_pkg::*;
#(
  parameter int STREAMS = TPS_STREAMS
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic [1:0] MODE,
  input wire logic HOST_VIA_PORT,
  input wire logic P1_RX_CLK,
  input wire logic P1_RX_DV,
  input wire logic [7:0] P1_RXD,
  input wire logic P1_TIMING,
  input wire logic P2_RX_CLK,
  input wire logic P2_RX_DV,
  input wire logic [7:0] P2_RXD,
  input wire logic P2_TIMING,
  output logic P1_TX_EN,
  output logic P1_TX_STB,
  output logic [7:0] P1_TXD,
  output logic P2_TX_EN,
  output logic P2_TX_STB,
  output logic [7:0] P2_TXD,
  output logic P1_REC_STB,
  output logic [7:0] P1_REC_DATA,
  output logic P2_REC_STB,
  output logic [7:0] P2_REC_DATA,
  output logic HOST_STB,
  output logic [7:0] HOST_DATA,
  input wire logic GEN_VALID,
  input wire logic [7:0] GEN_DATA,
  input wire logic GEN_LAST,
  output logic GEN_READY,
  input wire logic CLS_VALID,
  input wire logic [1:0] CLS_STREAM,
  input wire logic [15:0] CLS_SEQ,
  input wire logic [15:0] CLS_OCTETS,
  input wire logic [15:0] CLS_DELAY,
  input wire logic PERIOD_RESTART,
  input wire logic [1:0] STAT_SEL,
  output logic [31:0] STAT_PKTS,
  output logic [31:0] STAT_OCTETS,
  output logic [31:0] STAT_LOST,
  output logic [31:0] STAT_EXT_SEQ,
  output logic [15:0] STAT_DV_MIN,
  output logic [15:0] STAT_DV_MAX
);

  // The stream select is two bits wide, so more than four streams cannot be reached.
  if (STREAMS < 1 || STREAMS > 4) begin : g_streams_bad
    $error("STREAMS must be 1 to 4");
  end

  // ----------------------------------------------------------------
  // Route selection
  // ----------------------------------------------------------------
  // An unused mode code behaves as listen-only, the one mode that can
  // never disturb the network.
  function automatic tps_route_t route_of(input logic timing, input logic port2,
                                          input logic [1:0] mode, input logic via);
    tps_route_t r;
    r = TPS_RT_DROP;
    if (timing) begin
      r = TPS_RT_REC;
    end else if (mode == TPS_MODE_PASS) begin
      r = TPS_RT_FWD;
    end else if (mode == TPS_MODE_ALONE) begin
      r = via ? TPS_RT_FWD : (port2 ? TPS_RT_DROP : TPS_RT_HOST);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Port input synchronisers and frame tracking
  // ----------------------------------------------------------------
  logic [1:0] clk_s1_reg, clk_s2_reg, clk_d_reg, dv_s1_reg, dv_s2_reg;
  logic [7:0] rxd_s1_reg [2];
  logic [7:0] rxd_s2_reg [2];
  logic [1:0] in_frame_reg, in_frame_next;
  tps_route_t route_reg [2];
  tps_route_t route_next [2];
  logic gen_act_reg, gen_act_next, gen_ready_next;
  logic [1:0] tx_en_next, tx_stb_next, rec_stb_next;
  logic [7:0] txd_next [2];
  logic [7:0] rec_data_next [2];
  logic host_stb_next;
  logic [7:0] host_data_next;
  logic [1:0] rx_ev;
  logic snoop, gen_take;
  tps_route_t cur [2];

  assign snoop = (MODE != TPS_MODE_PASS) && (MODE != TPS_MODE_ALONE);
  // An offer still standing as the mode turns listen-only is dropped, since
  // silence on the ports outranks the generator's handshake.
  assign gen_take = GEN_READY && GEN_VALID && !snoop;
  // The link clock is sampled, so a byte is taken on its rising edge.
  assign rx_ev = clk_s2_reg & ~clk_d_reg;

  always_comb begin
    in_frame_next = in_frame_reg;
    route_next = route_reg;
    gen_act_next = gen_act_reg;
    tx_stb_next = 2'h0;
    rec_stb_next = 2'h0;
    txd_next[0] = P1_TXD;
    txd_next[1] = P2_TXD;
    rec_data_next[0] = P1_REC_DATA;
    rec_data_next[1] = P2_REC_DATA;
    host_stb_next = 1'h0;
    host_data_next = HOST_DATA;
    for (int i = 0; i < 2; i++) begin
      cur[i] = in_frame_reg[i] ? route_reg[i]
             : route_of(i == 0 ? P1_TIMING : P2_TIMING, i == 1, MODE, HOST_VIA_PORT);
      if (rx_ev[i]) begin
        in_frame_next[i] = dv_s2_reg[i];
        route_next[i] = cur[i];
        if (dv_s2_reg[i]) begin
          unique case (cur[i])
            TPS_RT_REC: begin
              rec_stb_next[i] = 1'h1;
              // Bytes reach recovery untouched, so sender timestamps stay valid.
              rec_data_next[i] = rxd_s2_reg[i];
            end
            TPS_RT_HOST: begin
              host_stb_next = !snoop;
              host_data_next = rxd_s2_reg[i];
            end
            TPS_RT_FWD: begin
              // A byte that meets a locally generated frame is lost.
              if (i == 0 || (!gen_act_reg && !gen_take)) begin
                tx_stb_next[1 - i] = !snoop;
                txd_next[1 - i] = rxd_s2_reg[i];
              end
            end
            TPS_RT_DROP: begin
            end
          endcase
        end
      end
    end
    if (gen_take) begin
      tx_stb_next[0] = 1'h1;
      txd_next[0] = GEN_DATA;
      gen_act_next = !GEN_LAST;
    end
    if (snoop) begin
      gen_act_next = 1'h0;
    end
    gen_ready_next = !snoop && (gen_act_next || !(in_frame_next[1] && route_next[1] == TPS_RT_FWD));
    tx_en_next[0] = !snoop && ((in_frame_next[1] && route_next[1] == TPS_RT_FWD)
                    || gen_act_next || tx_stb_next[0]);
    tx_en_next[1] = !snoop && in_frame_next[0] && route_next[0] == TPS_RT_FWD;
  end

  // All state, port logic included, runs on the system clock.
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      clk_s1_reg <= 2'h0;
      clk_s2_reg <= 2'h0;
      clk_d_reg <= 2'h0;
      dv_s1_reg <= 2'h0;
      dv_s2_reg <= 2'h0;
      rxd_s1_reg <= '{8'h00, 8'h00};
      rxd_s2_reg <= '{8'h00, 8'h00};
      in_frame_reg <= 2'h0;
      route_reg <= '{TPS_RT_DROP, TPS_RT_DROP};
      gen_act_reg <= 1'h0;
      GEN_READY <= 1'h0;
      {P1_TX_EN, P2_TX_EN, P1_TX_STB, P2_TX_STB} <= 4'h0;
      {P1_TXD, P2_TXD, P1_REC_DATA, P2_REC_DATA} <= 32'h0000_0000;
      {P1_REC_STB, P2_REC_STB, HOST_STB} <= 3'h0;
      HOST_DATA <= 8'h00;
    end else if (CE) begin
      clk_s1_reg <= {P2_RX_CLK, P1_RX_CLK};
      clk_s2_reg <= clk_s1_reg;
      clk_d_reg <= clk_s2_reg;
      dv_s1_reg <= {P2_RX_DV, P1_RX_DV};
      dv_s2_reg <= dv_s1_reg;
      rxd_s1_reg <= '{P1_RXD, P2_RXD};
      rxd_s2_reg <= rxd_s1_reg;
      in_frame_reg <= in_frame_next;
      route_reg <= route_next;
      gen_act_reg <= gen_act_next;
      GEN_READY <= gen_ready_next;
      {P2_TX_EN, P1_TX_EN} <= tx_en_next;
      {P2_TX_STB, P1_TX_STB} <= tx_stb_next;
      P1_TXD <= txd_next[0];
      P2_TXD <= txd_next[1];
      {P2_REC_STB, P1_REC_STB} <= rec_stb_next;
      P1_REC_DATA <= rec_data_next[0];
      P2_REC_DATA <= rec_data_next[1];
      HOST_STB <= host_stb_next;
      HOST_DATA <= host_data_next;
    end
  end

  // ----------------------------------------------------------------
  // Per-stream statistics
  // ----------------------------------------------------------------
  logic [31:0] pkts_reg [STREAMS];
  logic [31:0] pkts_next [STREAMS];
  logic [31:0] oct_reg [STREAMS];
  logic [31:0] oct_next [STREAMS];
  logic [31:0] lost_reg [STREAMS];
  logic [31:0] lost_next [STREAMS];
  logic [31:0] ext_reg [STREAMS];
  logic [31:0] ext_next [STREAMS];
  logic [15:0] dmin_reg [STREAMS];
  logic [15:0] dmin_next [STREAMS];
  logic [15:0] dmax_reg [STREAMS];
  logic [15:0] dmax_next [STREAMS];
  logic [STREAMS-1:0] seen_reg, seen_next, fresh_reg, fresh_next;
  logic [15:0] gap;
  int unsigned s, q;

  always_comb begin
    s = 32'(CLS_STREAM) % STREAMS;
    q = 32'(STAT_SEL) % STREAMS;
    pkts_next = pkts_reg;
    oct_next = oct_reg;
    lost_next = lost_reg;
    ext_next = ext_reg;
    dmin_next = dmin_reg;
    dmax_next = dmax_reg;
    seen_next = seen_reg;
    fresh_next = PERIOD_RESTART ? {STREAMS{1'b1}} : fresh_reg;
    gap = CLS_SEQ - ext_reg[s][15:0];
    if (CLS_VALID) begin
      pkts_next[s] = pkts_reg[s] + 32'h0000_0001;
      oct_next[s] = oct_reg[s] + {16'h0000, CLS_OCTETS};
      seen_next[s] = 1'h1;
      fresh_next[s] = 1'h0;
      if (!seen_reg[s]) begin
        ext_next[s] = {16'h0000, CLS_SEQ};
      end else if (gap != 16'h0000 && gap < TPS_SEQ_HALF) begin
        // Late and duplicate packets leave the highest number alone.
        lost_next[s] = lost_reg[s] + {16'h0000, gap - 16'h0001};
        ext_next[s][15:0] = CLS_SEQ;
        if (CLS_SEQ < ext_reg[s][15:0]) begin
          ext_next[s][31:16] = ext_reg[s][31:16] + 16'h0001;
        end
      end
      if (fresh_reg[s] || PERIOD_RESTART) begin
        dmin_next[s] = CLS_DELAY;
        dmax_next[s] = CLS_DELAY;
      end else begin
        dmin_next[s] = (CLS_DELAY < dmin_reg[s]) ? CLS_DELAY : dmin_reg[s];
        dmax_next[s] = (CLS_DELAY > dmax_reg[s]) ? CLS_DELAY : dmax_reg[s];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      for (int i = 0; i < STREAMS; i++) begin
        pkts_reg[i] <= TPS_CNT_RST;
        oct_reg[i] <= TPS_CNT_RST;
        lost_reg[i] <= TPS_CNT_RST;
        ext_reg[i] <= TPS_CNT_RST;
        dmin_reg[i] <= TPS_DV_RST;
        dmax_reg[i] <= TPS_DV_RST;
      end
      seen_reg <= '0;
      fresh_reg <= '1;
      {STAT_PKTS, STAT_OCTETS, STAT_LOST, STAT_EXT_SEQ} <= 128'h0;
      {STAT_DV_MIN, STAT_DV_MAX} <= 32'h0000_0000;
    end else if (CE) begin
      pkts_reg <= pkts_next;
      oct_reg <= oct_next;
      lost_reg <= lost_next;
      ext_reg <= ext_next;
      dmin_reg <= dmin_next;
      dmax_reg <= dmax_next;
      seen_reg <= seen_next;
      fresh_reg <= fresh_next;
      STAT_PKTS <= pkts_reg[q];
      STAT_OCTETS <= oct_reg[q];
      STAT_LOST <= lost_reg[q];
      STAT_EXT_SEQ <= ext_reg[q];
      STAT_DV_MIN <= dmin_reg[q];
      STAT_DV_MAX <= dmax_reg[q];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [31:0] h_pkts_reg, h_oct_reg, h_lost_reg;
  logic [15:0] h_seq_reg, h_oct_in_reg, h_dly_reg;
  int unsigned h_s_reg;
  always_ff @(posedge MCLK) begin
    h_s_reg <= s;
    h_pkts_reg <= pkts_reg[s];
    h_oct_reg <= oct_reg[s];
    h_lost_reg <= lost_reg[s];
    h_seq_reg <= CLS_SEQ;
    h_oct_in_reg <= CLS_OCTETS;
    h_dly_reg <= CLS_DELAY;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  sequence rx_byte(int p, tps_route_t r);
    CE && rx_ev[p] && dv_s2_reg[p] && cur[p] == r;
  endsequence

  AST_SNOOP_SILENT: assert property (CE && snoop |=> !P1_TX_STB && !P2_TX_STB)
    else $error("transmit seen in listen-only mode");
  AST_SNOOP_NO_HOST: assert property (CE && snoop && MODE != TPS_MODE_ALONE |=> !HOST_STB)
    else $error("host byte in listen-only mode");
  AST_TIMING_REC: assert property (rx_byte(0, TPS_RT_REC) |=> P1_REC_STB && !P2_TX_STB)
    else $error("timing byte not diverted");
  AST_PASS_FWD: assert property (rx_byte(1, TPS_RT_FWD) ##0 (!snoop && !gen_act_reg && !gen_take)
                                 |=> P1_TX_STB && P1_TXD == $past(rxd_s2_reg[1]))
    else $error("customer byte not relayed");
  AST_FWD_OPP: assert property (rx_byte(0, TPS_RT_FWD) ##0 !snoop |=> P2_TX_STB && P2_TX_EN)
    else $error("byte not forwarded to opposite port");
  AST_HOST_PATH: assert property (rx_byte(0, TPS_RT_HOST) ##0 !snoop |=> HOST_STB && !P2_TX_STB)
    else $error("non-timing byte not sent to host");
  AST_GEN_MERGE: assert property (CE && gen_take |=> P1_TX_STB && P1_TXD == $past(GEN_DATA))
    else $error("generated byte not merged");
  AST_PKT_CNT: assert property (CE && CLS_VALID |=> pkts_reg[h_s_reg] == h_pkts_reg + 32'h1)
    else $error("packet count not advanced");
  AST_OCT_CNT: assert property (CE && CLS_VALID |=>
                                oct_reg[h_s_reg] == h_oct_reg + {16'h0, h_oct_in_reg})
    else $error("octet count wrong");
  AST_LOST_UP: assert property (CE && CLS_VALID |=> lost_reg[h_s_reg] - h_lost_reg < 32'h8000)
    else $error("lost count moved wrongly");
  AST_EXT_LOW: assert property (CE && CLS_VALID && !seen_reg[s] |=>
                                ext_reg[h_s_reg] == {16'h0, h_seq_reg})
    else $error("extended sequence not loaded");
  AST_DV_SPAN: assert property (CE && CLS_VALID |=> dmin_reg[h_s_reg] <= h_dly_reg
                                && dmax_reg[h_s_reg] >= h_dly_reg)
    else $error("delay variation span excludes sample");

endmodule

// *** tb/tps_phy_model.sv ***
// PHY-side model of one packet port: link clock, frame valid, data, verdict.
// Assumes the block samples all four lines with its own clock.
`timescale 1ns/1ps
module tps_phy_model (
  output logic rx_clk,
  output logic rx_dv,
  output logic [7:0] rxd,
  output logic timing
);
  initial begin
    rx_clk = 1'b0;
    rx_dv = 1'b0;
    rxd = 8'h00;
    timing = 1'b0;
  end

  // The link clock runs one cycle past the frame, with the last byte inverted on that cycle.
  // This keeps a block that samples stale data from passing by luck.
  task automatic send(input logic [31:0] w, input logic tm, input int ph);
    #(ph);
    timing = tm;
    for (int i = 0; i < 5; i++) begin
      rx_dv = (i < 4);
      rxd = (i < 4) ? w[8*i +: 8] : ~rxd;
      #200 rx_clk = 1'b1;
      #200 rx_clk = 1'b0;
    end
    rxd = ~rxd;
  endtask
endmodule

// *** tb/tps_steer_bench.sv ***
// Self-checking bench for the steering and statistics block.
// Assumes PHY models on both ports; the bench acts as classifier and host.
`timescale 1ns/1ps
module tps_steer_bench;
  import tps_pkg::*;
  logic MCLK = 1'b0;
  logic NRST = 1'b0;
  logic CE = 1'b1;
  logic [1:0] MODE = 2'h0;
  logic HOST_VIA_PORT = 1'b0;
  logic GEN_VALID = 1'b0;
  logic GEN_LAST = 1'b0;
  logic [7:0] GEN_DATA = 8'h00;
  logic CLS_VALID = 1'b0;
  logic PERIOD_RESTART = 1'b0;
  logic [1:0] CLS_STREAM = 2'h0;
  logic [1:0] STAT_SEL = 2'h0;
  logic [15:0] CLS_SEQ = 16'h0000;
  logic [15:0] CLS_OCTETS = 16'h0000;
  logic [15:0] CLS_DELAY = 16'h0000;
  logic P1_RX_CLK, P1_RX_DV, P1_TIMING, P2_RX_CLK, P2_RX_DV, P2_TIMING, GEN_READY;
  logic P1_TX_EN, P1_TX_STB, P2_TX_EN, P2_TX_STB, P1_REC_STB, P2_REC_STB, HOST_STB;
  logic [7:0] P1_RXD, P2_RXD, P1_TXD, P2_TXD, P1_REC_DATA, P2_REC_DATA, HOST_DATA;
  logic [31:0] STAT_PKTS, STAT_OCTETS, STAT_LOST, STAT_EXT_SEQ;
  logic [15:0] STAT_DV_MIN, STAT_DV_MAX;
  int errors = 0;
  int checks = 0;
  int cnt [5];
  logic [31:0] sum [5];
  int en_cyc;
  logic [31:0] e_pkts [4] = '{default: 32'h0};
  logic [31:0] e_oct [4] = '{default: 32'h0};
  logic [31:0] e_lost [4] = '{default: 32'h0};
  logic [31:0] e_ext [4] = '{default: 32'h0};
  logic [15:0] e_min [4] = '{default: 16'h0};
  logic [15:0] e_max [4] = '{default: 16'h0};
  logic [3:0] seen = 4'h0;
  logic [3:0] fresh = 4'hF;
  wire logic [4:0] stb = {HOST_STB, P2_REC_STB, P1_REC_STB, P2_TX_STB, P1_TX_STB};
  wire logic [39:0] dat = {HOST_DATA, P2_REC_DATA, P1_REC_DATA, P2_TXD, P1_TXD};

  always #25 MCLK = ~MCLK;

  tps_steer i_dut (.MCLK(MCLK), .NRST(NRST), .CE(CE), .MODE(MODE),
    .HOST_VIA_PORT(HOST_VIA_PORT), .P1_RX_CLK(P1_RX_CLK), .P1_RX_DV(P1_RX_DV),
    .P1_RXD(P1_RXD), .P1_TIMING(P1_TIMING), .P2_RX_CLK(P2_RX_CLK), .P2_RX_DV(P2_RX_DV),
    .P2_RXD(P2_RXD), .P2_TIMING(P2_TIMING), .P1_TX_EN(P1_TX_EN), .P1_TX_STB(P1_TX_STB),
    .P1_TXD(P1_TXD), .P2_TX_EN(P2_TX_EN), .P2_TX_STB(P2_TX_STB), .P2_TXD(P2_TXD),
    .P1_REC_STB(P1_REC_STB), .P1_REC_DATA(P1_REC_DATA), .P2_REC_STB(P2_REC_STB),
    .P2_REC_DATA(P2_REC_DATA), .HOST_STB(HOST_STB), .HOST_DATA(HOST_DATA),
    .GEN_VALID(GEN_VALID), .GEN_DATA(GEN_DATA), .GEN_LAST(GEN_LAST),
    .GEN_READY(GEN_READY), .CLS_VALID(CLS_VALID), .CLS_STREAM(CLS_STREAM),
    .CLS_SEQ(CLS_SEQ), .CLS_OCTETS(CLS_OCTETS), .CLS_DELAY(CLS_DELAY),
    .PERIOD_RESTART(PERIOD_RESTART), .STAT_SEL(STAT_SEL), .STAT_PKTS(STAT_PKTS),
    .STAT_OCTETS(STAT_OCTETS), .STAT_LOST(STAT_LOST), .STAT_EXT_SEQ(STAT_EXT_SEQ),
    .STAT_DV_MIN(STAT_DV_MIN), .STAT_DV_MAX(STAT_DV_MAX));
  tps_phy_model i_p1 (.rx_clk(P1_RX_CLK), .rx_dv(P1_RX_DV), .rxd(P1_RXD), .timing(P1_TIMING));
  tps_phy_model i_p2 (.rx_clk(P2_RX_CLK), .rx_dv(P2_RX_DV), .rxd(P2_RXD), .timing(P2_TIMING));

  // ----------------------------------------------------------------
  // Output monitor and helpers
  // ----------------------------------------------------------------
  always @(posedge MCLK) begin
    for (int k = 0; k < 5; k++) begin
      if (stb[k] === 1'b1) begin
        cnt[k]++;
        sum[k] += dat[8*k +: 8];
      end
    end
    if (P1_TX_EN === 1'b1 || P2_TX_EN === 1'b1) begin
      en_cyc++;
    end
  end

  task automatic clear();
    cnt = '{default: 0};
    sum = '{default: 32'h0};
    en_cyc = 0;
  endtask

  task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
    checks++;
    if (seen_v !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen_v);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Index of the strobe that should carry a frame, 5 when it must vanish.
  function automatic int dest(input logic [1:0] m, input logic v, input int p, input logic t);
    if (t) return 2 + p;
    if (m == TPS_MODE_PASS || (m == TPS_MODE_ALONE && v)) return 1 - p;
    if (m == TPS_MODE_ALONE && p == 0) return 4;
    return 5;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] w;
    logic [31:0] bs;
    logic [15:0] sq, gap;
    int d, n, s;
    logic v, rs;
    void'($urandom(32'h7283));
    clear();
    repeat (10) @(posedge MCLK);
    #2 NRST = 1'b1;
    check("pkts_rst", STAT_PKTS, 32'h0);
    for (int c = 0; c < 32; c++) begin
      @(posedge MCLK);
      #2;
      MODE = c[4:3];
      HOST_VIA_PORT = c[2];
      w = $urandom;
      bs = w[7:0] + w[15:8] + w[23:16] + w[31:24];
      clear();
      if (c[1]) i_p2.send(w, c[0], $urandom_range(1, 399));
      else i_p1.send(w, c[0], $urandom_range(1, 399));
      repeat (20) @(posedge MCLK);
      d = dest(c[4:3], c[2], int'(c[1]), c[0]);
      for (int k = 0; k < 5; k++) begin
        check("strobes", cnt[k], (k == d) ? 4 : 0);
        check("bytesum", sum[k], (k == d) ? bs : 0);
      end
      if (c[4:3] != TPS_MODE_PASS && c[4:3] != TPS_MODE_ALONE) check("tx_en", en_cyc, 0);
    end
    $display("frame steering test done");
    #2 MODE = TPS_MODE_PASS;
    w = $urandom;
    clear();
    for (int i = 0; i < 3; i++) begin
      GEN_VALID = 1'b1;
      GEN_DATA = w[8*i +: 8];
      GEN_LAST = (i == 2);
      n = 0;
      while (GEN_READY !== 1'b1 && n < 20) begin
        @(posedge MCLK);
        #2;
        n++;
      end
      check("gen_ready", n < 20, 1'b1);
      if (n == 20) give_verdict();
      @(posedge MCLK);
      #2;
    end
    GEN_VALID = 1'b0;
    GEN_LAST = 1'b0;
    repeat (4) @(posedge MCLK);
    check("gen_cnt", cnt[0], 3);
    check("gen_sum", sum[0], w[7:0] + w[15:8] + w[23:16]);
    #2 MODE = TPS_MODE_SNOOP;
    repeat (2) @(posedge MCLK);
    #2 clear();
    GEN_VALID = 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge MCLK);
      #2;
      if (GEN_READY !== 1'b0) n++;
    end
    GEN_VALID = 1'b0;
    check("snoop_ready", n, 0);
    check("snoop_tx", cnt[0] + en_cyc, 0);
    $display("generated frame test done");
    for (int i = 0; i < 400; i++) begin
      @(posedge MCLK);
      #2;
      s = $urandom_range(0, 3);
      v = ($urandom_range(0, 1) == 1);
      rs = ($urandom_range(0, 15) == 0);
      gap = ($urandom_range(0, 9) == 0) ? 16'h9000 : 16'($urandom_range(0, 3));
      sq = seen[s] ? e_ext[s][15:0] + gap : 16'hFFF8;
      CLS_VALID = v;
      PERIOD_RESTART = rs;
      CLS_STREAM = 2'(s);
      CLS_SEQ = sq;
      CLS_OCTETS = 16'($urandom);
      CLS_DELAY = 16'($urandom);
      if (rs) fresh = 4'hF;
      if (v) begin
        e_pkts[s] += 1;
        e_oct[s] += CLS_OCTETS;
        if (!seen[s]) e_ext[s] = {16'h0000, sq};
        else if (gap != 0 && gap < TPS_SEQ_HALF) begin
          e_lost[s] += gap - 1;
          e_ext[s] = {e_ext[s][31:16] + 16'(sq < e_ext[s][15:0]), sq};
        end
        seen[s] = 1'b1;
        if (fresh[s] || CLS_DELAY < e_min[s]) e_min[s] = CLS_DELAY;
        if (fresh[s] || CLS_DELAY > e_max[s]) e_max[s] = CLS_DELAY;
        fresh[s] = 1'b0;
      end
    end
    @(posedge MCLK);
    #2 CLS_VALID = 1'b0;
    PERIOD_RESTART = 1'b0;
    for (int k = 0; k < 4; k++) begin
      STAT_SEL = 2'(k);
      repeat (2) @(posedge MCLK);
      #2;
      check("pkts", STAT_PKTS, e_pkts[k]);
      check("octets", STAT_OCTETS, e_oct[k]);
      check("lost", STAT_LOST, e_lost[k]);
      check("ext_seq", STAT_EXT_SEQ, e_ext[k]);
      check("dv_min", STAT_DV_MIN, e_min[k]);
      check("dv_max", STAT_DV_MAX, e_max[k]);
    end
    $display("statistics test done");
    // Offers made while the enable is low must leave the packet counter frozen.
    CE = 1'b0;
    CLS_VALID = 1'b1;
    CLS_STREAM = 2'h3;
    repeat (3) @(posedge MCLK);
    #2 CLS_VALID = 1'b0;
    CE = 1'b1;
    repeat (2) @(posedge MCLK);
    #2 check("ce_hold", STAT_PKTS, e_pkts[3]);
    NRST = 1'b0;
    repeat (3) @(posedge MCLK);
    #2 NRST = 1'b1;
    check("pkts_clr", STAT_PKTS, 32'h0);
    check("ext_clr", STAT_EXT_SEQ, 32'h0);
    $display("enable and reset test done");
    give_verdict();
  end
endmodule
